// file: design/stl_pkg.sv
// Package for the system time loop control block: map, layouts, resets, timing.
package stl_pkg;
  localparam logic [11:0] SYS_TIME_ADDR = 12'h910;
  localparam logic [11:0] TIME_OFFSET_ADDR = 12'h920;
  localparam logic [11:0] PROPAGATION_DELAY_ADDR = 12'h928;
  localparam logic [11:0] MEAN_TIME_DIFFERENCE_ADDR = 12'h92c;
  localparam logic [11:0] LOOP_BANDWIDTH_START_ADDR = 12'h930;
  localparam logic [11:0] CLOCK_PERIOD_DEVIATION_ADDR = 12'h932;
  localparam logic [11:0] DIFFERENCE_FILTER_DEPTH_ADDR = 12'h934;
  localparam logic [11:0] DEVIATION_FILTER_DEPTH_ADDR = 12'h935;
  localparam int DIFF_SIGN_BIT = 31;
  localparam int SPEED_START_MSB = 14;
  localparam int DEPTH_MSB = 3;
  localparam logic [14:0] LOOP_BANDWIDTH_START_RST = 15'h1000;
  localparam logic [3:0] DIFFERENCE_FILTER_DEPTH_RST = 4'h4;
  localparam logic [3:0] DEVIATION_FILTER_DEPTH_RST = 4'hc;
  localparam logic [15:0] DEVIATION_MARGIN = 16'h007f;
  localparam int CLOCK_RATE_MHZ = 100;
  localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_RATE_MHZ;
  localparam logic [63:0] TIME_STEP_NS = 64'(CLOCK_PERIOD_NS);

  typedef struct packed {
    logic we;
    logic re;
    logic [11:0] addr;
    logic [7:0] wdata;
  } stl_bus_req_t;

  typedef struct packed {
    logic [63:0] local_time;
    logic [63:0] offset;
    logic [31:0] delay;
    logic signed [31:0] mean;
    logic [14:0] speed_start;
    logic signed [15:0] dev;
    logic [3:0] diff_depth;
    logic [3:0] dev_depth;
    logic [15:0] corr_cnt;
    logic [15:0] vote_cnt;
    logic signed [15:0] vote_acc;
    logic [63:0] sof_latch;
    logic [31:0] rx_time;
    logic rx_armed;
    logic [7:0] fb_rdata;
    logic [7:0] host_rdata;
    logic [63:0] sys_time;
  } stl_state_t;
endpackage

// file: design/stl_time_loop.sv
// Time loop control: offset, delay, mean difference filter and speed counter.
`timescale 1ns/1ps
`default_nettype none
module stl_time_loop import stl_pkg::*; (
  input wire logic I_CLOCK, // System clock
  input wire logic I_RST, // Async reset, high
  input wire stl_bus_req_t I_FB_REQ, // Fieldbus side byte access
  input wire stl_bus_req_t I_HOST_REQ, // Local host port byte access
  input wire logic I_HOST_TIME_CTRL, // Host controls system time
  input wire logic I_FRAME_START, // Frame start delimiter pulse
  input wire logic I_FRAME_END, // Frame end pulse
  output logic [7:0] O_FB_RDATA, // Fieldbus read byte
  output logic [7:0] O_HOST_RDATA, // Host read byte
  output logic [63:0] O_SYS_TIME // Local copy of system time
);
  stl_state_t s;
  stl_state_t next_s;
  logic wr_ok;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic signed [31:0] diff;
  logic [15:0] abs_dev;
  logic [15:0] period;
  logic signed [15:0] lim;
  logic signed [15:0] new_dev;
  logic signed [15:0] vote_sum;

  function automatic logic [7:0] read_byte(input stl_state_t st, input logic [11:0] a);
    logic [31:0] mag;
    logic [31:0] mw;
    logic [63:0] ofs;
    mag = st.mean[31] ? 32'(-st.mean) : 32'(st.mean);
    if (mag[31]) begin
      mag = 32'h7fffffff;
    end
    mw = {st.mean[31], mag[30:0]};
    ofs = st.offset;
    read_byte = 8'h00;
    if (a[11:3] == SYS_TIME_ADDR[11:3]) begin
      read_byte = st.sys_time[8*a[2:0] +: 8];
    end else if (a[11:3] == TIME_OFFSET_ADDR[11:3]) begin
      read_byte = ofs[8*a[2:0] +: 8];
    end else if (a[11:2] == PROPAGATION_DELAY_ADDR[11:2]) begin
      read_byte = st.delay[8*a[1:0] +: 8];
    end else if (a[11:2] == MEAN_TIME_DIFFERENCE_ADDR[11:2]) begin
      read_byte = mw[8*a[1:0] +: 8];
    end else if (a == LOOP_BANDWIDTH_START_ADDR) begin
      read_byte = st.speed_start[7:0];
    end else if (a == LOOP_BANDWIDTH_START_ADDR + 12'h001) begin
      read_byte = {1'b0, st.speed_start[14:8]};
    end else if (a == CLOCK_PERIOD_DEVIATION_ADDR) begin
      read_byte = st.dev[7:0];
    end else if (a == CLOCK_PERIOD_DEVIATION_ADDR + 12'h001) begin
      read_byte = st.dev[15:8];
    end else if (a == DIFFERENCE_FILTER_DEPTH_ADDR) begin
      read_byte = {4'h0, st.diff_depth};
    end else if (a == DEVIATION_FILTER_DEPTH_ADDR) begin
      read_byte = {4'h0, st.dev_depth};
    end
  endfunction

  always_comb begin
    next_s = s;
    // Fieldbus wins if both ports write in one cycle
    wr_ok = I_FB_REQ.we || (I_HOST_REQ.we && I_HOST_TIME_CTRL);
    wr_addr = I_FB_REQ.we ? I_FB_REQ.addr : I_HOST_REQ.addr;
    wr_data = I_FB_REQ.we ? I_FB_REQ.wdata : I_HOST_REQ.wdata;
    diff = $signed(s.sof_latch[31:0] - s.rx_time);
    abs_dev = s.dev[15] ? 16'(-s.dev) : 16'(s.dev);
    period = {1'b0, s.speed_start} - abs_dev;
    lim = $signed({1'b0, s.speed_start} - DEVIATION_MARGIN);
    if (lim < 0) begin
      lim = 16'sh0000;
    end
    new_dev = s.dev;
    // Sum including this compare's vote, so the step sees the final tally
    vote_sum = s.vote_acc + ((diff < 0) ? 16'sh0001 : (diff > 0) ? -16'sh0001 : 16'sh0000);

    // Local time with fine correction; never below the margin period
    next_s.local_time = s.local_time + TIME_STEP_NS;
    if (s.dev != 0) begin
      if (s.corr_cnt + 16'h0001 >= period) begin
        next_s.corr_cnt = 16'h0000;
        next_s.local_time = s.dev[15] ? s.local_time + TIME_STEP_NS - 64'h1
                                      : s.local_time + TIME_STEP_NS + 64'h1;
      end else begin
        next_s.corr_cnt = s.corr_cnt + 16'h0001;
      end
    end else begin
      next_s.corr_cnt = 16'h0000;
    end

    if (I_FRAME_START) begin
      next_s.sof_latch = s.sys_time + {32'h0, s.delay};
    end

    // Difference filter and speed vote at frame end
    if (I_FRAME_END && s.rx_armed) begin
      next_s.rx_armed = 1'b0;
      next_s.mean = s.mean + ((diff - s.mean) >>> s.diff_depth);
      next_s.vote_acc = vote_sum;
      next_s.vote_cnt = s.vote_cnt + 16'h0001;
      if (s.vote_cnt >= (16'h0001 << s.dev_depth) - 16'h0001) begin
        next_s.vote_cnt = 16'h0000;
        next_s.vote_acc = 16'sh0000;
        if (vote_sum > 0) begin
          new_dev = s.dev + 16'sh0001;
        end else if (vote_sum < 0) begin
          new_dev = s.dev - 16'sh0001;
        end
        if (new_dev > lim) begin
          new_dev = lim;
        end else if (new_dev < -lim) begin
          new_dev = -lim;
        end
        next_s.dev = new_dev;
      end
    end

    if (I_FB_REQ.we && I_FB_REQ.addr[11:2] == SYS_TIME_ADDR[11:2]) begin
      next_s.rx_time[8*I_FB_REQ.addr[1:0] +: 8] = I_FB_REQ.wdata;
      if (I_FB_REQ.addr[1:0] == 2'b00) begin
        next_s.rx_armed = 1'b1;
      end
    end

    if (wr_ok) begin
      if (wr_addr[11:3] == TIME_OFFSET_ADDR[11:3]) begin
        next_s.offset[8*wr_addr[2:0] +: 8] = wr_data;
      end else if (wr_addr[11:2] == PROPAGATION_DELAY_ADDR[11:2]) begin
        next_s.delay[8*wr_addr[1:0] +: 8] = wr_data;
      end else if (wr_addr[11:1] == LOOP_BANDWIDTH_START_ADDR[11:1]) begin
        if (wr_addr[0]) begin
          next_s.speed_start[14:8] = wr_data[6:0];
        end else begin
          next_s.speed_start[7:0] = wr_data;
        end
        // Also restarts both filters so stale history cannot kick the loop
        next_s.mean = 32'sh0;
        next_s.dev = 16'sh0;
        next_s.vote_cnt = 16'h0000;
        next_s.vote_acc = 16'sh0000;
        next_s.corr_cnt = 16'h0000;
      end else if (wr_addr == DIFFERENCE_FILTER_DEPTH_ADDR) begin
        next_s.diff_depth = wr_data[DEPTH_MSB:0];
        next_s.mean = 32'sh0;
      end else if (wr_addr == DEVIATION_FILTER_DEPTH_ADDR) begin
        next_s.dev_depth = wr_data[DEPTH_MSB:0];
        next_s.vote_cnt = 16'h0000;
        next_s.vote_acc = 16'sh0000;
      end
    end

    next_s.sys_time = next_s.local_time + next_s.offset;
    if (I_FB_REQ.re) begin
      next_s.fb_rdata = read_byte(s, I_FB_REQ.addr);
    end
    if (I_HOST_REQ.re) begin
      next_s.host_rdata = read_byte(s, I_HOST_REQ.addr);
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      s <= '0;
      s.speed_start <= LOOP_BANDWIDTH_START_RST;
      s.diff_depth <= DIFFERENCE_FILTER_DEPTH_RST;
      s.dev_depth <= DEVIATION_FILTER_DEPTH_RST;
    end else begin
      s <= next_s;
    end
  end

  assign O_FB_RDATA = s.fb_rdata;
  assign O_HOST_RDATA = s.host_rdata;
  assign O_SYS_TIME = s.sys_time;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  sys_time_sum_a: assert property (O_SYS_TIME == s.local_time + s.offset)
    else $error("system time is not local time plus offset");
  host_blocked_a: assert property (I_HOST_REQ.we && !I_HOST_TIME_CTRL && !I_FB_REQ.we
    |=> $stable(s.offset) && $stable(s.delay) && $stable(s.speed_start))
    else $error("host write accepted without host time control");
  delay_latch_a: assert property (I_FRAME_START |=> s.sof_latch == $past(s.sys_time) + {32'h0, $past(s.delay)})
    else $error("frame start latch misses delay");
  diff_sign_a: assert property (I_FB_REQ.re && I_FB_REQ.addr == MEAN_TIME_DIFFERENCE_ADDR + 12'h003
    |=> O_FB_RDATA[7] == $past(s.mean[DIFF_SIGN_BIT]))
    else $error("difference sign bit wrong");
  start_clear_a: assert property (wr_ok && wr_addr[11:1] == LOOP_BANDWIDTH_START_ADDR[11:1]
    |=> s.mean == 0 && s.dev == 0 && s.vote_cnt == 0)
    else $error("speed start write did not clear filters");
  dev_limit_a: assert property (s.dev <= lim && s.dev >= -lim)
    else $error("deviation outside its range");
  depth_clear_a: assert property (wr_ok && wr_addr == DIFFERENCE_FILTER_DEPTH_ADDR |=> s.mean == 0)
    else $error("difference depth write did not clear mean");
  dev_reset_a: assert property (wr_ok && wr_addr == DEVIATION_FILTER_DEPTH_ADDR
    |=> s.vote_cnt == 0 && s.vote_acc == 0)
    else $error("deviation depth write did not reset filter");
  compare_done_a: assert property (I_FRAME_END && s.rx_armed && !I_FB_REQ.we |=> !s.rx_armed)
    else $error("armed compare not consumed at frame end");
  step_size_a: assert property (s.dev == 0 && $past(s.dev) == 0 && !wr_ok
    |=> s.local_time - $past(s.local_time) == TIME_STEP_NS)
    else $error("uncorrected step is not one clock period");

  compare_c: cover property (I_FRAME_END && s.rx_armed);
  speed_up_c: cover property (s.dev > 0 && s.corr_cnt == 0);
  host_write_c: cover property (I_HOST_REQ.we && I_HOST_TIME_CTRL && !I_FB_REQ.we);
endmodule
`default_nettype wire

// file: verification/stl_bus_model.sv
// Byte bus master and frame pulse source standing in for the far side.
`timescale 1ns/1ps
`default_nettype none
module stl_bus_model import stl_pkg::*; (
  input wire logic I_CLOCK, // System clock
  input wire logic [7:0] i_rdata, // Read byte from block
  output var stl_bus_req_t o_req, // Byte access request
  output var logic o_frame_start, // Frame start pulse
  output var logic o_frame_end // Frame end pulse
);
  initial begin
    o_req = '0;
    o_frame_start = 1'b0;
    o_frame_end = 1'b0;
  end
  // Idle bus shows inverted address and data, never a stale copy
  task automatic access(input logic we, input logic [11:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge I_CLOCK);
    o_req <= '{we: we, re: !we, addr: addr, wdata: wdata};
    @(posedge I_CLOCK);
    o_req <= '{we: 1'b0, re: 1'b0, addr: ~addr, wdata: ~wdata};
    #1 rdata = i_rdata;
  endtask
  task automatic frame(input logic [31:0] rx_time);
    logic [7:0] unused;
    @(posedge I_CLOCK);
    o_frame_start <= 1'b1;
    @(posedge I_CLOCK);
    o_frame_start <= 1'b0;
    for (int i = 0; i < 4; i++) access(1'b1, SYS_TIME_ADDR + 12'(i), rx_time[8*i +: 8], unused);
    @(posedge I_CLOCK);
    o_frame_end <= 1'b1;
    @(posedge I_CLOCK);
    o_frame_end <= 1'b0;
    @(posedge I_CLOCK);
  endtask
endmodule
`default_nettype wire

// file: verification/stl_time_loop_bench.sv
// Self-checking bench for the time loop register block.
`timescale 1ns/1ps
`default_nettype none
module stl_time_loop_bench import stl_pkg::*; ;
  logic I_CLOCK = 1'b0;
  logic I_RST = 1'b1;
  logic host_ctrl = 1'b0;
  stl_bus_req_t fb_req;
  stl_bus_req_t host_req;
  logic fb_start;
  logic fb_end;
  logic [7:0] fb_rdata;
  logic [7:0] host_rdata;
  logic [7:0] rd;
  logic [63:0] sys_time;
  logic [63:0] t0;
  int bad_count = 0;
  int comparisons = 0;
  always #5 I_CLOCK = ~I_CLOCK;
  stl_time_loop stl_time_loop_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_FB_REQ(fb_req), .I_HOST_REQ(host_req),
    .I_HOST_TIME_CTRL(host_ctrl), .I_FRAME_START(fb_start), .I_FRAME_END(fb_end), .O_FB_RDATA(fb_rdata),
    .O_HOST_RDATA(host_rdata), .O_SYS_TIME(sys_time));
  stl_bus_model fb_model (.I_CLOCK(I_CLOCK), .i_rdata(fb_rdata), .o_req(fb_req), .o_frame_start(fb_start),
    .o_frame_end(fb_end));
  stl_bus_model host_model (.I_CLOCK(I_CLOCK), .i_rdata(host_rdata), .o_req(host_req), .o_frame_start(),
    .o_frame_end());
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fb_wr(input logic [11:0] addr, input logic [7:0] data);
    fb_model.access(1'b1, addr, data, rd);
  endtask
  task automatic fb_rd(input logic [11:0] addr, input logic [7:0] exp);
    fb_model.access(1'b0, addr, 8'h00, rd);
    check(64'(rd), 64'(exp));
  endtask
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    fb_rd(LOOP_BANDWIDTH_START_ADDR + 12'h1, 8'h10);
    fb_rd(DIFFERENCE_FILTER_DEPTH_ADDR, 8'h04);
    fb_rd(DEVIATION_FILTER_DEPTH_ADDR, 8'h0c);
    fb_rd(12'h936, 8'h00);
    // Host write while the fieldbus owns the loop must be dropped
    host_model.access(1'b1, PROPAGATION_DELAY_ADDR, 8'h55, rd);
    fb_rd(PROPAGATION_DELAY_ADDR, 8'h00);
    @(posedge I_CLOCK);
    host_ctrl <= 1'b1;
    host_model.access(1'b1, PROPAGATION_DELAY_ADDR, 8'h55, rd);
    fb_rd(PROPAGATION_DELAY_ADDR, 8'h55);
    host_model.access(1'b0, PROPAGATION_DELAY_ADDR, 8'h00, rd);
    check(64'(rd), 64'h55);
    fb_wr(TIME_OFFSET_ADDR + 12'h7, 8'h80);
    fb_rd(TIME_OFFSET_ADDR + 12'h7, 8'h80);
    check(64'(sys_time[63]), 64'h1);
    fb_wr(LOOP_BANDWIDTH_START_ADDR + 12'h1, 8'hff);
    fb_rd(LOOP_BANDWIDTH_START_ADDR + 12'h1, 8'h7f);
    fb_wr(LOOP_BANDWIDTH_START_ADDR + 12'h1, 8'h10);
    // Received time far ahead: local copy is behind, mean is diff/16
    fb_model.frame(32'h4000_0000);
    fb_rd(MEAN_TIME_DIFFERENCE_ADDR + 12'h3, 8'h83);
    fb_wr(LOOP_BANDWIDTH_START_ADDR, 8'h00);
    fb_rd(MEAN_TIME_DIFFERENCE_ADDR + 12'h3, 8'h00);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR, 8'h00);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR + 12'h1, 8'h00);
    fb_model.frame(32'h4000_0000);
    fb_rd(MEAN_TIME_DIFFERENCE_ADDR + 12'h3, 8'h83);
    fb_wr(DIFFERENCE_FILTER_DEPTH_ADDR, 8'hf2);
    fb_rd(MEAN_TIME_DIFFERENCE_ADDR + 12'h3, 8'h00);
    fb_rd(DIFFERENCE_FILTER_DEPTH_ADDR, 8'h02);
    fb_wr(DEVIATION_FILTER_DEPTH_ADDR, 8'hf3);
    fb_rd(DEVIATION_FILTER_DEPTH_ADDR, 8'h03);
    // Depth 0 and start 0x80: every compare steps the deviation, which holds at its limit of 1
    fb_wr(DEVIATION_FILTER_DEPTH_ADDR, 8'h00);
    fb_wr(LOOP_BANDWIDTH_START_ADDR + 12'h1, 8'h00);
    fb_wr(LOOP_BANDWIDTH_START_ADDR, 8'h80);
    fb_model.frame(32'h4000_0000);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR, 8'h01);
    fb_model.frame(32'h4000_0000);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR, 8'h01);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR + 12'h1, 8'h00);
    // Any 127 cycles (start minus deviation) hold exactly one 11 ns step
    @(posedge I_CLOCK);
    #1 t0 = sys_time;
    repeat (127) @(posedge I_CLOCK);
    #1 check(sys_time - t0, 64'd1271);
    // Received time zero: local copy ahead, deviation falls to the negative limit
    fb_model.frame(32'h0000_0000);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR, 8'h00);
    fb_model.frame(32'h0000_0000);
    fb_model.frame(32'h0000_0000);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR, 8'hff);
    fb_rd(CLOCK_PERIOD_DEVIATION_ADDR + 12'h1, 8'hff);
    @(posedge I_CLOCK);
    #1 t0 = sys_time;
    repeat (127) @(posedge I_CLOCK);
    #1 check(sys_time - t0, 64'd1269);
    complete_run();
  end
endmodule
`default_nettype wire
